/* File: verilog/adc_seq_device.sv */
// Purpose: delta-sigma conversion sequencer and decimator control
// Assumes: modulator bitstream arrives asynchronously, one bit per clock
// Notes: decimator is a four-period moving sum of ones counts
//
// Contract
// - four modes: single, continuous, multi, turbo
// - start bit or trigger input begins conversion
// - result ready sets status, eoc until read
// - single mode waits in standby for trigger
// - single: three priming conversions, fourth gives result
// - after single read, back to standby
// - continuous: three-period latency, then every period
// - multi: re-prime between samples, auto relaunch
// - turbo: like multi below 17 bits, else no reset
// - output needs four samples after input change
// - resolution sets period, trading rate for bits
// - one-bit stream becomes parallel result words
// - collector polls status or uses eoc
// - trigger optional in continuous mode
// - no input switching during continuous mode
`timescale 1ns/10ps
`default_nettype none
module adc_seq_device #(
   parameter int OSR_SHIFT = adc_seq_pkg::OSR_SHIFT_DEF
) (
   // link to collecting party
   adc_seq_if.device bus,
   // modulator bitstream
   input wire logic mod_bit,
   // local status
   output logic conv_active
);
   localparam int CNT_W = adc_seq_pkg::CNT_W;
   localparam int HIST_W = adc_seq_pkg::HIST_W;
   localparam int SUM_W = adc_seq_pkg::SUM_W;
   localparam int DATA_W = adc_seq_pkg::DATA_W;
   localparam int RES_W = adc_seq_pkg::RES_W;

   logic mod_s1_r;
   logic mod_s2_r;
   adc_seq_pkg::seq_state_t state_r;
   adc_seq_pkg::seq_state_t state_nxt;
   adc_seq_pkg::mode_t mode_r;
   logic [RES_W-1:0] res_r;
   logic [RES_W-1:0] res_clamp;
   logic [CNT_W-1:0] last_r;
   logic [CNT_W-1:0] bit_cnt_r;
   logic [HIST_W-1:0] ones_r;
   logic [HIST_W-1:0] ones_now;
   logic [HIST_W-1:0] hist_r [adc_seq_pkg::PIPE_DEPTH-1];
   logic [adc_seq_pkg::FILL_W-1:0] fill_r;
   logic [SUM_W-1:0] sum4;
   logic [SUM_W+1:0] scaled;
   logic [SUM_W+1:0] lim;
   logic [DATA_W-1:0] result_nxt;
   logic [adc_seq_pkg::CH_W-1:0] chan_r;
   logic trig;
   logic launch;
   logic period_end;
   logic result_ready;
   logic reprime;
   logic chan_chg;
   logic eoc_r;
   logic status_r;
   logic busy_r;
   logic [DATA_W-1:0] result_r;

   // bits per period, 2^(res - shift); wider words take longer
   function automatic logic [CNT_W-1:0] period_last(
      input logic [RES_W-1:0] r
   );
      logic [CNT_W:0] one_sh;
      logic [RES_W-1:0] sh;
      sh = '0;
      if (r > RES_W'(OSR_SHIFT)) begin
         sh = r - RES_W'(OSR_SHIFT);
      end
      one_sh = {{CNT_W{1'b0}}, 1'b1} << sh;
      return one_sh[CNT_W-1:0] - 1'b1;
   endfunction

   // bitstream is an analog-side level, synchronise first
   always_ff @(posedge bus.clk_sys or negedge bus.rstn) begin
      if (!bus.rstn) begin
         mod_s1_r <= 1'b0;
         mod_s2_r <= 1'b0;
      end else begin
         mod_s1_r <= mod_bit;
         mod_s2_r <= mod_s1_r;
      end
   end

   always_comb begin
      res_clamp = bus.res;
      if (bus.res < adc_seq_pkg::RES_MIN) begin
         res_clamp = adc_seq_pkg::RES_MIN;
      end else if (bus.res > adc_seq_pkg::RES_MAX) begin
         res_clamp = adc_seq_pkg::RES_MAX;
      end
   end

   assign trig = bus.start_req | bus.soc;
   assign launch = (state_r == adc_seq_pkg::ST_STANDBY) && trig;
   assign period_end = (state_r == adc_seq_pkg::ST_CONVERT) &&
                       (bit_cnt_r == last_r);
   assign ones_now = ones_r + HIST_W'(mod_s2_r);
   assign chan_chg = bus.chan_sel != chan_r;
   // fill counts finished periods; fourth one yields a word
   assign result_ready = period_end && (fill_r == adc_seq_pkg::FILL_FULL) &&
                         !chan_chg;
   assign reprime = result_ready &&
                    ((mode_r == adc_seq_pkg::MODE_MULTI) ||
                     ((mode_r == adc_seq_pkg::MODE_TURBO) &&
                      (res_r < adc_seq_pkg::TURBO_RES_MIN)));

   // moving sum over the newest four periods, scaled to res bits
   always_comb begin
      sum4 = SUM_W'(ones_now) + SUM_W'(hist_r[0]) + SUM_W'(hist_r[1]) +
             SUM_W'(hist_r[2]);
      scaled = {sum4, {adc_seq_pkg::SCALE_SH{1'b0}}};
      lim = {{(SUM_W+1){1'b0}}, 1'b1} << res_r;
      result_nxt = DATA_W'(scaled);
      if (scaled >= lim) begin
         result_nxt = DATA_W'(lim - 1'b1);
      end
   end

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         adc_seq_pkg::ST_STANDBY: begin
            if (trig) begin
               state_nxt = adc_seq_pkg::ST_CONVERT;
            end
         end
         adc_seq_pkg::ST_CONVERT: begin
            if (bus.stop_req) begin
               state_nxt = adc_seq_pkg::ST_STANDBY;
            end else if (result_ready &&
                         mode_r == adc_seq_pkg::MODE_SINGLE) begin
               state_nxt = adc_seq_pkg::ST_HOLD;
            end
         end
         adc_seq_pkg::ST_HOLD: begin
            if (bus.rd_req || bus.stop_req) begin
               state_nxt = adc_seq_pkg::ST_STANDBY;
            end
         end
         default: state_nxt = adc_seq_pkg::ST_STANDBY;
      endcase
   end

   always_ff @(posedge bus.clk_sys or negedge bus.rstn) begin
      if (!bus.rstn) begin
         state_r <= adc_seq_pkg::ST_STANDBY;
      end else begin
         state_r <= state_nxt;
      end
   end

   // settings are frozen for the whole run
   always_ff @(posedge bus.clk_sys or negedge bus.rstn) begin
      if (!bus.rstn) begin
         mode_r <= adc_seq_pkg::MODE_SINGLE;
         res_r <= adc_seq_pkg::RES_MIN;
         last_r <= '0;
      end else if (launch) begin
         mode_r <= bus.mode;
         res_r <= res_clamp;
         last_r <= period_last(res_clamp);
      end
   end

   always_ff @(posedge bus.clk_sys or negedge bus.rstn) begin
      if (!bus.rstn) begin
         chan_r <= '0;
      end else begin
         chan_r <= bus.chan_sel;
      end
   end

   always_ff @(posedge bus.clk_sys or negedge bus.rstn) begin
      if (!bus.rstn) begin
         bit_cnt_r <= '0;
         ones_r <= '0;
      end else if (launch || period_end || chan_chg) begin
         bit_cnt_r <= '0;
         ones_r <= '0;
      end else if (state_r == adc_seq_pkg::ST_CONVERT) begin
         bit_cnt_r <= bit_cnt_r + 1'b1;
         ones_r <= ones_now;
      end
   end

   // history and fill; a channel change or a reset-style mode
   // empties the pipe so stale periods never leak into a word
   always_ff @(posedge bus.clk_sys or negedge bus.rstn) begin
      if (!bus.rstn) begin
         fill_r <= '0;
         for (int i = 0; i < adc_seq_pkg::PIPE_DEPTH - 1; i++) begin
            hist_r[i] <= '0;
         end
      end else if (launch || reprime || chan_chg) begin
         fill_r <= '0;
         for (int i = 0; i < adc_seq_pkg::PIPE_DEPTH - 1; i++) begin
            hist_r[i] <= '0;
         end
      end else if (period_end) begin
         if (fill_r != adc_seq_pkg::FILL_FULL) begin
            fill_r <= fill_r + 1'b1;
         end
         hist_r[0] <= ones_now;
         for (int i = 1; i < adc_seq_pkg::PIPE_DEPTH - 1; i++) begin
            hist_r[i] <= hist_r[i-1];
         end
      end
   end

   always_ff @(posedge bus.clk_sys or negedge bus.rstn) begin
      if (!bus.rstn) begin
         result_r <= '0;
      end else if (result_ready) begin
         result_r <= result_nxt;
      end
   end

   // a new word in the read cycle keeps the flags up
   always_ff @(posedge bus.clk_sys or negedge bus.rstn) begin
      if (!bus.rstn) begin
         eoc_r <= 1'b0;
         status_r <= 1'b0;
      end else if (result_ready) begin
         eoc_r <= 1'b1;
         status_r <= 1'b1;
      end else if (bus.rd_req) begin
         eoc_r <= 1'b0;
         status_r <= 1'b0;
      end
   end

   always_ff @(posedge bus.clk_sys or negedge bus.rstn) begin
      if (!bus.rstn) begin
         busy_r <= 1'b0;
         conv_active <= 1'b0;
      end else begin
         busy_r <= state_nxt != adc_seq_pkg::ST_STANDBY;
         conv_active <= state_nxt == adc_seq_pkg::ST_CONVERT;
      end
   end

   assign bus.eoc = eoc_r;
   assign bus.status = status_r;
   assign bus.busy = busy_r;
   assign bus.result = result_r;
endmodule // adc_seq_device
`default_nettype wire

/* File: verilog/adc_seq_pkg.sv */
// Purpose: shared constants and types for the conversion sequencer link
// Assumes: one system clock on both ends
// Notes: widths sized for 20-bit results and 2^20 bit periods
`default_nettype none
package adc_seq_pkg;
   typedef enum logic [1:0] {
      MODE_SINGLE = 2'h0,
      MODE_CONT   = 2'h1,
      MODE_MULTI  = 2'h2,
      MODE_TURBO  = 2'h3
   } mode_t;
   // gray along standby -> convert -> hold
   typedef enum logic [1:0] {
      ST_STANDBY = 2'h0,
      ST_CONVERT = 2'h1,
      ST_HOLD    = 2'h3
   } seq_state_t;
   localparam int RES_W = 5;
   localparam logic [RES_W-1:0] RES_MIN = 5'h08;
   localparam logic [RES_W-1:0] RES_MAX = 5'h14;
   localparam logic [RES_W-1:0] TURBO_RES_MIN = 5'h11;
   localparam int DATA_W = 20;
   localparam int CH_W = 3;
   localparam int PIPE_DEPTH = 4;
   localparam int FILL_W = 2;
   localparam logic [FILL_W-1:0] FILL_FULL = 2'h3;
   localparam int CNT_W = 20;
   localparam int HIST_W = CNT_W + 1;
   localparam int SUM_W = HIST_W + 2;
   localparam int SCALE_SH = 2;
   localparam int OSR_SHIFT_DEF = 4;
endpackage
`default_nettype wire

/* File: verilog/adc_seq_if.sv */
// Purpose: link between the converter sequencer and its collecting party
// Assumes: both ends on clk_sys
// Notes: all signals are single-driver levels or one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
interface adc_seq_if (
   input wire logic clk_sys,
   input wire logic rstn
);
   logic start_req;
   logic stop_req;
   logic soc;
   adc_seq_pkg::mode_t mode;
   logic [adc_seq_pkg::RES_W-1:0] res;
   logic [adc_seq_pkg::CH_W-1:0] chan_sel;
   logic rd_req;
   logic eoc;
   logic status;
   logic busy;
   logic [adc_seq_pkg::DATA_W-1:0] result;

   modport device (
      input clk_sys, rstn, start_req, stop_req, soc, mode, res,
      input chan_sel, rd_req,
      output eoc, status, busy, result
   );
   modport host (
      input clk_sys, rstn, eoc, status, busy, result,
      output start_req, stop_req, soc, mode, res, chan_sel, rd_req
   );
endinterface
`default_nettype wire

/* File: verilog/adc_seq_host.sv */
// Purpose: collecting party that starts conversions and reads results
// Assumes: user-side signals are on clk_sys
// Notes: read pulse is never back to back, eoc needs a cycle to fall
`timescale 1ns/10ps
`default_nettype none
module adc_seq_host #(
   parameter bit USE_POLL = 1'b0
) (
   // link to converter
   adc_seq_if.host bus,
   // user commands and settings
   input wire logic cmd_start,
   input wire logic cmd_stop,
   input wire adc_seq_pkg::mode_t cfg_mode,
   input wire logic [adc_seq_pkg::RES_W-1:0] cfg_res,
   input wire logic [adc_seq_pkg::CH_W-1:0] cfg_chan,
   // optional trigger source
   input wire logic trig_in,
   input wire logic trig_en,
   // collected data
   output logic [adc_seq_pkg::DATA_W-1:0] data_out,
   output logic data_valid,
   output logic chan_held
);
   logic start_r;
   logic stop_r;
   logic soc_r;
   adc_seq_pkg::mode_t mode_r;
   logic [adc_seq_pkg::RES_W-1:0] res_r;
   logic [adc_seq_pkg::CH_W-1:0] chan_r;
   logic rd_r;
   logic done;
   logic lock_chan;

   assign done = USE_POLL ? bus.status : bus.eoc;
   assign lock_chan = bus.busy && (mode_r == adc_seq_pkg::MODE_CONT);

   always_ff @(posedge bus.clk_sys or negedge bus.rstn) begin
      if (!bus.rstn) begin
         start_r <= 1'b0;
         stop_r <= 1'b0;
         soc_r <= 1'b0;
         mode_r <= adc_seq_pkg::MODE_SINGLE;
         res_r <= adc_seq_pkg::RES_MIN;
      end else begin
         start_r <= cmd_start;
         stop_r <= cmd_stop;
         soc_r <= trig_en & trig_in;
         mode_r <= cfg_mode;
         res_r <= cfg_res;
      end
   end

   // mixing inputs in continuous mode blends channels, so hold it
   always_ff @(posedge bus.clk_sys or negedge bus.rstn) begin
      if (!bus.rstn) begin
         chan_r <= '0;
         chan_held <= 1'b0;
      end else begin
         chan_held <= lock_chan && (cfg_chan != chan_r);
         if (!lock_chan) begin
            chan_r <= cfg_chan;
         end
      end
   end

   always_ff @(posedge bus.clk_sys or negedge bus.rstn) begin
      if (!bus.rstn) begin
         rd_r <= 1'b0;
         data_out <= '0;
         data_valid <= 1'b0;
      end else begin
         rd_r <= done && !rd_r;
         data_valid <= rd_r;
         if (rd_r) begin
            data_out <= bus.result;
         end
      end
   end

   assign bus.start_req = start_r;
   assign bus.stop_req = stop_r;
   assign bus.soc = soc_r;
   assign bus.mode = mode_r;
   assign bus.res = res_r;
   assign bus.chan_sel = chan_r;
   assign bus.rd_req = rd_r;
endmodule // adc_seq_host
`default_nettype wire

/* File: tb/adc_seq_chk.sv */
// Purpose: checker on the sequencer link signals
// Assumes: OSR_SHIFT equals the device setting
// Notes: word timing allows two cycles of slack for register stages
`timescale 1ns/10ps
`default_nettype none
module adc_seq_chk #(
   parameter int OSR_SHIFT = 4
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // host to device
   input wire logic start_req,
   input wire logic stop_req,
   input wire logic soc,
   input wire adc_seq_pkg::mode_t mode,
   input wire logic [adc_seq_pkg::RES_W-1:0] res,
   input wire logic rd_req,
   input wire logic [adc_seq_pkg::CH_W-1:0] chan_sel,
   // device to host
   input wire logic eoc,
   input wire logic status,
   input wire logic busy,
   input wire logic [adc_seq_pkg::DATA_W-1:0] result
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   logic [16:0] gap_r;
   logic first_r;
   adc_seq_pkg::mode_t lm_r;
   logic [adc_seq_pkg::RES_W-1:0] lr_r;
   wire logic launch = !busy && (start_req || soc);
   function automatic bit near(input logic [16:0] g, input int n);
      return (g + 2 >= n) && (g <= n + 2);
   endfunction
   function automatic int nxt(input adc_seq_pkg::mode_t m, input int r);
      // continuous-like modes keep history, so words come every period
      if (m == adc_seq_pkg::MODE_CONT ||
          (m == adc_seq_pkg::MODE_TURBO && r >= 17)) begin
         return 1 << (r - OSR_SHIFT);
      end
      return 4 << (r - OSR_SHIFT);
   endfunction
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         gap_r <= 17'h0;
         first_r <= 1'b0;
      end else if (launch || (busy && $changed(chan_sel))) begin
         // a new input restarts priming, so word timing restarts too
         gap_r <= 17'h1;
         first_r <= 1'b1;
      end else if ($rose(eoc)) begin
         gap_r <= 17'h1;
         first_r <= 1'b0;
      end else begin
         gap_r <= gap_r + 17'h1;
      end
   end
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lm_r <= adc_seq_pkg::MODE_SINGLE;
         lr_r <= adc_seq_pkg::RES_MIN;
      end else if (launch) begin
         lm_r <= mode;
         lr_r <= res;
      end
   end
   sequence s_launch;
      !busy && (start_req || soc);
   endsequence
   sequence s_word;
      $rose(eoc);
   endsequence
   AST_RST_IDLE: assert property (
      $rose(rstn) |-> !busy && !eoc && !status)
      else $error("not idle after reset");
   AST_START_BUSY: assert property (s_launch |=> busy)
      else $error("start not taken");
   AST_IDLE_STAY: assert property (
      !busy && !start_req && !soc |=> !busy)
      else $error("left standby unprompted");
   AST_EOC_HOLD: assert property (eoc && !rd_req |=> eoc)
      else $error("eoc fell without a read");
   AST_EOC_STATUS: assert property (eoc == status)
      else $error("status differs from eoc");
   AST_FIRST_WORD: assert property (s_word and first_r |->
      near(gap_r, 4 << (lr_r - OSR_SHIFT)))
      else $error("first word at wrong time");
   AST_NEXT_WORD: assert property (s_word and !first_r |->
      near(gap_r, nxt(lm_r, lr_r)))
      else $error("word spacing wrong");
   AST_SINGLE_ONE: assert property (s_word and lm_r ==
      adc_seq_pkg::MODE_SINGLE |-> first_r)
      else $error("second word in single mode");
   AST_SINGLE_DONE: assert property (busy && rd_req &&
      lm_r == adc_seq_pkg::MODE_SINGLE |-> ##[1:2] !busy)
      else $error("single mode did not return to standby");
   AST_RES_FIT: assert property (eoc |-> (result >> lr_r) == 0)
      else $error("result wider than resolution");
   AST_STOP: assert property (stop_req && busy |-> ##[1:2] !busy)
      else $error("stop not obeyed");
endmodule // adc_seq_chk
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: self-checking bench for both ends of the sequencer link
// Assumes: OSR_SHIFT 6 so an 8-bit period is 4 clocks
// Notes: constant bitstream per test gives 2^(res-2) or zero
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic cmd_start, cmd_stop, trig_in, trig_en, mod_bit;
   adc_seq_pkg::mode_t cfg_mode;
   logic [4:0] cfg_res;
   logic [2:0] cfg_chan;
   logic [19:0] data_out;
   logic data_valid, chan_held, conv_active;
   logic [19:0] exp_q[$];
   int miscompares = 0;
   int checked = 0;
   int cyc = 0;
   int got = 0;
   always #4 clk_sys = ~clk_sys;
   adc_seq_if adc_seq_if_i (.clk_sys(clk_sys), .rstn(rstn));
   adc_seq_device #(.OSR_SHIFT(6)) adc_seq_device_i (.bus(adc_seq_if_i),
      .mod_bit(mod_bit), .conv_active(conv_active));
   adc_seq_host adc_seq_host_i (.bus(adc_seq_if_i), .cmd_start(cmd_start),
      .cmd_stop(cmd_stop), .cfg_mode(cfg_mode), .cfg_res(cfg_res),
      .cfg_chan(cfg_chan), .trig_in(trig_in), .trig_en(trig_en),
      .data_out(data_out), .data_valid(data_valid), .chan_held(chan_held));
   adc_seq_chk #(.OSR_SHIFT(6)) adc_seq_chk_i (.clk_sys(clk_sys),
      .rstn(rstn), .start_req(adc_seq_if_i.start_req),
      .stop_req(adc_seq_if_i.stop_req), .soc(adc_seq_if_i.soc),
      .mode(adc_seq_if_i.mode), .res(adc_seq_if_i.res),
      .rd_req(adc_seq_if_i.rd_req), .chan_sel(adc_seq_if_i.chan_sel),
      .eoc(adc_seq_if_i.eoc),
      .status(adc_seq_if_i.status), .busy(adc_seq_if_i.busy),
      .result(adc_seq_if_i.result));
   task automatic check(string what, logic [19:0] e, logic [19:0] s);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic end_of_test();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // hang guard: longest test is the 17-bit turbo run, about 12.3k cycles
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 60000) begin
         miscompares++;
         end_of_test();
      end
   end
   always @(posedge clk_sys) begin
      if (data_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("spare word", 20'h0, 20'hFFFFF);
         end else begin
            check("data_out", exp_q.pop_front(), data_out);
         end
         got++;
      end
   end
   task automatic run(adc_seq_pkg::mode_t m, int r, int n, bit trig);
      int w;
      logic [19:0] held_exp;
      w = 0;
      @(posedge clk_sys);
      #1;
      mod_bit = 1'($urandom % 2);
      cfg_mode = m;
      cfg_res = r[4:0];
      cfg_chan = 3'($urandom % 8);
      got = 0;
      repeat (4) @(posedge clk_sys);
      #1;
      for (int i = 0; i < n; i++) begin
         exp_q.push_back(mod_bit ? 20'h1 << (r - 2) : 20'h0);
      end
      trig_in = trig;
      cmd_start = !trig;
      @(posedge clk_sys);
      #1;
      trig_in = 1'b0;
      cmd_start = 1'b0;
      // input switch mid-run: held off in continuous, re-primes otherwise
      held_exp = 20'(m == adc_seq_pkg::MODE_CONT);
      repeat (3) @(posedge clk_sys);
      #1;
      cfg_chan = cfg_chan + 3'h1;
      @(posedge clk_sys);
      #1;
      check("chan_held", held_exp, {19'h0, chan_held});
      while (got < n && w < (16 << (r - 6)) * (n + 1) + 40) begin
         @(posedge clk_sys);
         w++;
      end
      #1;
      cmd_stop = (m != adc_seq_pkg::MODE_SINGLE);
      @(posedge clk_sys);
      #1;
      cmd_stop = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      check("busy after run", 20'h0, {19'h0, adc_seq_if_i.busy});
      check("words", 20'(n), 20'(got));
      $display("test mode %0d res %0d done", m, r);
   endtask
   initial begin
      cmd_start = 1'b0;
      cmd_stop = 1'b0;
      trig_in = 1'b0;
      trig_en = 1'b1;
      mod_bit = 1'b0;
      cfg_mode = adc_seq_pkg::MODE_SINGLE;
      cfg_res = 5'h08;
      cfg_chan = 3'h0;
      void'($urandom(32'h389C));
      repeat (8) @(posedge clk_sys);
      #1;
      rstn = 1'b1;
      repeat (20) @(posedge clk_sys);
      #1;
      check("idle busy", 20'h0, {19'h0, adc_seq_if_i.busy});
      check("idle active", 20'h0, {19'h0, conv_active});
      $display("test idle done");
      run(adc_seq_pkg::MODE_SINGLE, 8 + $urandom % 9, 1, 1'b0);
      run(adc_seq_pkg::MODE_SINGLE, 10, 1, 1'b1);
      run(adc_seq_pkg::MODE_CONT, 12, 3, 1'b0);
      run(adc_seq_pkg::MODE_MULTI, 8, 3, 1'b0);
      run(adc_seq_pkg::MODE_TURBO, 8, 2, 1'b1);
      run(adc_seq_pkg::MODE_TURBO, 17, 3, 1'b0);
      end_of_test();
   end
endmodule // tb
`default_nettype wire
